// File: verilog/acvp_map.vh
// Constants of the analog channel value processing block.
// Assumes inclusion by bare name from the design files only.
`ifndef ACVP_MAP_VH
`define ACVP_MAP_VH

// ----------------------------------------
// Register byte offsets
// ----------------------------------------
`define ACVP_OFS_CTRL 8'h00
`define ACVP_OFS_RANGE 8'h04
`define ACVP_OFS_THRESH 8'h08
`define ACVP_OFS_SIMVAL 8'h0C
`define ACVP_OFS_SUBVAL 8'h10
`define ACVP_OFS_STATUS 8'h14
`define ACVP_OFS_MEAS 8'h18

// ----------------------------------------
// Control field positions
// ----------------------------------------
`define ACVP_CTRL_SIM 0
`define ACVP_CTRL_POL_LO 1
`define ACVP_CTRL_POL_HI 2
`define ACVP_CTRL_STAT 3
`define ACVP_CTRL_LFD 4
`define ACVP_CTRL_HART 5
`define ACVP_CTRL_SCAN 6
`define ACVP_CTRL_AUX_LO 7
`define ACVP_CTRL_AUX_HI 9

// ----------------------------------------
// Fault policy encodings
// ----------------------------------------
`define ACVP_POL_CURRENT 2'h0
`define ACVP_POL_SUBST 2'h1
`define ACVP_POL_LAST 2'h2

// ----------------------------------------
// Reset values
// ----------------------------------------
`define ACVP_RST_START 16'h2710
`define ACVP_RST_END 16'hC350
`define ACVP_RST_SHORT 16'h5208
`define ACVP_RST_BREAK 16'h03E8
`define ACVP_RST_SIMVAL 16'h0000
`define ACVP_RST_SUBVAL 16'h0000

// ----------------------------------------
// Loop current figures in microamps
// ----------------------------------------
`define ACVP_UA_ZERO 17'sh0_0FA0
`define ACVP_UA_SPAN 34'sh0_0000_3E80
`define ACVP_UA_LIVE_ZERO 16'h0E10

// ----------------------------------------
// Telegram layout
// ----------------------------------------
`define ACVP_CFG_BASE 8'h50
`define ACVP_STD_BYTES 5'h02
`define ACVP_AUX_BYTES 5'h04
`define ACVP_AUX_MAX 3'h4

// ----------------------------------------
// Auxiliary refresh divider
// ----------------------------------------
`define ACVP_AUX_DIV 8'h03

`endif

// File: verilog/acvp_channel.v
// One analog input channel: source choice, fault policy, scaling, status bits,
// line fault detection and HART auxiliary telegram layout, with AXI4-Lite registers.
// Assumes current samples and HART variables come from logic on aclk.
//
// How it works
// - Normal mode reports the value scaled from the measured loop current.
// - Simulation mode reports the preset simulation value instead of the field.
// - Current-value policy keeps the present signal during a fault, simulated or not.
// - Substitute policy reports the configured substitute value while the fault lasts.
// - Last-valid policy holds the last value seen before the fault began.
// - With status enabled, status bits go into the data word.
// - Non-default scaling endpoints drop the status bits whatever the option.
// - Zero percent maps to start, full scale to end; defaults 10000 and 50000.
// - Enabled line fault detection raises a diagnosis and applies the fault policy.
// - Current above the short-circuit threshold flags a short circuit.
// - Current below the breakage threshold flags a lead breakage.
// - Telegram is two bytes plus zero to four four-byte auxiliary variables.
// - Configuration code is 50 plus twice the auxiliary count, in hex.
// - Auxiliary variables refresh less often than the standard word.
// - HART communication can be switched on or off for the channel.
// - HART switch editable only with individual deactivation; otherwise stays on.
// - Auxiliary count editable only with extended fieldbus modes turned on.
// - HART-enabled channel is scanned for identifiers and variables by default.
// - The four low bits of the data word carry status, not resolution.
// - Bit 1 of the low byte flags a line fault, one meaning error.
//
// The AXI4-Lite register port and the address map are this design's own decisions.
`timescale 1ns/100ps
`include "acvp_map.vh"

module acvp_channel #(
    parameter AUX_DIV = 8,
    parameter VAR_W = 32
) (
    // Clock and reset
    input wire aclk,
    input wire aresetn,
    // AXI4-Lite write address
    input wire [7:0] s_axi_awaddr,
    input wire s_axi_awvalid,
    output reg s_axi_awready,
    // AXI4-Lite write data
    input wire [31:0] s_axi_wdata,
    input wire [3:0] s_axi_wstrb,
    input wire s_axi_wvalid,
    output reg s_axi_wready,
    // AXI4-Lite write response
    output reg [1:0] s_axi_bresp,
    output reg s_axi_bvalid,
    input wire s_axi_bready,
    // AXI4-Lite read address
    input wire [7:0] s_axi_araddr,
    input wire s_axi_arvalid,
    output reg s_axi_arready,
    // AXI4-Lite read data
    output reg [31:0] s_axi_rdata,
    output reg [1:0] s_axi_rresp,
    output reg s_axi_rvalid,
    input wire s_axi_rready,
    // Measured loop current
    input wire [15:0] meas_ua,
    input wire meas_valid,
    // HART auxiliary variables from the modem side
    input wire [4*VAR_W-1:0] hart_var,
    // Communication unit feature switches
    input wire feat_indiv_deact,
    input wire feat_ext_modes,
    // Cyclic data to the communication unit
    output reg [15:0] proc_word,
    output reg proc_valid,
    output reg [4*VAR_W-1:0] aux_data,
    output reg aux_valid,
    output reg [7:0] cfg_code,
    output reg [4:0] telegram_len,
    // Diagnosis
    output reg diag_short,
    output reg diag_break,
    output reg diag_fault,
    // HART control
    output reg hart_active,
    output reg hart_scan
);

// ----------------------------------------
// Configuration registers
// ----------------------------------------
reg sim_mode;
reg [1:0] fault_pol;
reg status_en;
reg lfd_en;
reg hart_en;
reg scan_en;
reg [2:0] aux_count;
reg [15:0] range_start;
reg [15:0] range_end;
reg [15:0] short_thr;
reg [15:0] break_thr;
reg [15:0] sim_value;
reg [15:0] sub_value;
reg [15:0] last_cur;
reg [15:0] last_valid;
reg live_zero;

// ----------------------------------------
// AXI4-Lite write path
// ----------------------------------------
reg aw_held;
reg w_held;
reg [7:0] aw_addr;
reg [31:0] w_data;
reg [3:0] w_strb;
wire wr_fire = aw_held && w_held && !s_axi_bvalid;
reg [31:0] wr_merge;
reg [31:0] wr_old;
reg wr_hit;
integer i;

always @* begin
    wr_old = 32'h0000_0000;
    wr_hit = 1'b1;
    case (aw_addr)
        `ACVP_OFS_CTRL: begin
            wr_old = {22'h00_0000, aux_count, scan_en, hart_en, lfd_en, status_en,
                fault_pol, sim_mode};
        end
        `ACVP_OFS_RANGE: begin
            wr_old = {range_end, range_start};
        end
        `ACVP_OFS_THRESH: begin
            wr_old = {break_thr, short_thr};
        end
        `ACVP_OFS_SIMVAL: begin
            wr_old = {16'h0000, sim_value};
        end
        `ACVP_OFS_SUBVAL: begin
            wr_old = {16'h0000, sub_value};
        end
        default: begin
            wr_hit = 1'b0;
        end
    endcase
    for (i = 0; i < 4; i = i + 1) begin
        wr_merge[i*8 +: 8] = w_strb[i] ? w_data[i*8 +: 8] : wr_old[i*8 +: 8];
    end
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_awready <= 1'b0;
        s_axi_wready <= 1'b0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp <= 2'b00;
        aw_held <= 1'b0;
        w_held <= 1'b0;
        aw_addr <= 8'h00;
        w_data <= 32'h0000_0000;
        w_strb <= 4'h0;
    end else begin
        s_axi_awready <= !aw_held && !s_axi_awready;
        s_axi_wready <= !w_held && !s_axi_wready;
        if (s_axi_awvalid && s_axi_awready) begin
            aw_held <= 1'b1;
            aw_addr <= s_axi_awaddr;
            s_axi_awready <= 1'b0;
        end
        if (s_axi_wvalid && s_axi_wready) begin
            w_held <= 1'b1;
            w_data <= s_axi_wdata;
            w_strb <= s_axi_wstrb;
            s_axi_wready <= 1'b0;
        end
        if (wr_fire) begin
            s_axi_bvalid <= 1'b1;
            s_axi_bresp <= wr_hit ? 2'b00 : 2'b10;
            aw_held <= 1'b0;
            w_held <= 1'b0;
        end
        if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// ----------------------------------------
// Register storage
// ----------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        sim_mode <= 1'b0;
        fault_pol <= `ACVP_POL_CURRENT;
        status_en <= 1'b1;
        lfd_en <= 1'b0;
        hart_en <= 1'b1;
        scan_en <= 1'b1;
        aux_count <= 3'h0;
        range_start <= `ACVP_RST_START;
        range_end <= `ACVP_RST_END;
        short_thr <= `ACVP_RST_SHORT;
        break_thr <= `ACVP_RST_BREAK;
        sim_value <= `ACVP_RST_SIMVAL;
        sub_value <= `ACVP_RST_SUBVAL;
    end else if (wr_fire && wr_hit) begin
        case (aw_addr)
            `ACVP_OFS_CTRL: begin
                sim_mode <= wr_merge[`ACVP_CTRL_SIM];
                fault_pol <= wr_merge[`ACVP_CTRL_POL_HI:`ACVP_CTRL_POL_LO];
                status_en <= wr_merge[`ACVP_CTRL_STAT];
                lfd_en <= wr_merge[`ACVP_CTRL_LFD];
                scan_en <= wr_merge[`ACVP_CTRL_SCAN];
                if (feat_indiv_deact) begin
                    hart_en <= wr_merge[`ACVP_CTRL_HART];
                end
                if (feat_ext_modes && wr_merge[`ACVP_CTRL_AUX_HI:`ACVP_CTRL_AUX_LO] <=
                        `ACVP_AUX_MAX) begin
                    aux_count <= wr_merge[`ACVP_CTRL_AUX_HI:`ACVP_CTRL_AUX_LO];
                end
            end
            `ACVP_OFS_RANGE: begin
                range_start <= wr_merge[15:0];
                range_end <= wr_merge[31:16];
            end
            `ACVP_OFS_THRESH: begin
                short_thr <= wr_merge[15:0];
                break_thr <= wr_merge[31:16];
            end
            `ACVP_OFS_SIMVAL: begin
                sim_value <= wr_merge[15:0];
            end
            `ACVP_OFS_SUBVAL: begin
                sub_value <= wr_merge[15:0];
            end
            default: begin
                sim_mode <= sim_mode;
            end
        endcase
    end
end

// ----------------------------------------
// AXI4-Lite read path
// ----------------------------------------
reg [31:0] rd_word;
reg rd_hit;

always @* begin
    rd_word = 32'h0000_0000;
    rd_hit = 1'b1;
    case (s_axi_araddr)
        `ACVP_OFS_CTRL: begin
            rd_word = {22'h00_0000, aux_count, scan_en, hart_active, lfd_en, status_en,
                fault_pol, sim_mode};
        end
        `ACVP_OFS_RANGE: begin
            rd_word = {range_end, range_start};
        end
        `ACVP_OFS_THRESH: begin
            rd_word = {break_thr, short_thr};
        end
        `ACVP_OFS_SIMVAL: begin
            rd_word = {16'h0000, sim_value};
        end
        `ACVP_OFS_SUBVAL: begin
            rd_word = {16'h0000, sub_value};
        end
        `ACVP_OFS_STATUS: begin
            rd_word = {proc_word, cfg_code, 4'h0, live_zero, diag_fault, diag_break,
                diag_short};
        end
        `ACVP_OFS_MEAS: begin
            rd_word = {16'h0000, last_cur};
        end
        default: begin
            rd_hit = 1'b0;
        end
    endcase
end

always @(posedge aclk) begin
    if (!aresetn) begin
        s_axi_arready <= 1'b0;
        s_axi_rvalid <= 1'b0;
        s_axi_rdata <= 32'h0000_0000;
        s_axi_rresp <= 2'b00;
    end else begin
        s_axi_arready <= !s_axi_rvalid && !s_axi_arready;
        if (s_axi_arvalid && s_axi_arready) begin
            s_axi_arready <= 1'b0;
            s_axi_rvalid <= 1'b1;
            s_axi_rdata <= rd_word;
            s_axi_rresp <= rd_hit ? 2'b00 : 2'b10;
        end
        if (s_axi_rvalid && s_axi_rready) begin
            s_axi_rvalid <= 1'b0;
        end
    end
end

// ----------------------------------------
// Scaling and threshold checks
// ----------------------------------------
reg signed [16:0] cur_ofs;
reg signed [16:0] span;
reg signed [33:0] prod;
reg signed [33:0] quo;
reg signed [34:0] sum;
reg [15:0] scaled;
reg is_short;
reg is_break;
reg fault_now;
reg scale_default;
reg [15:0] source_val;
reg [15:0] next_value;
reg [15:0] next_word;

always @* begin
    // linear map from 4..20 mA onto start..end
    cur_ofs = $signed({1'b0, meas_ua}) - `ACVP_UA_ZERO;
    span = $signed({1'b0, range_end}) - $signed({1'b0, range_start});
    prod = $signed({{17{cur_ofs[16]}}, cur_ofs}) * $signed({{17{span[16]}}, span});
    quo = prod / `ACVP_UA_SPAN;
    sum = {quo[33], quo} + $signed({19'h0_0000, range_start});
    if (sum < 35'sh0) begin
        scaled = 16'h0000;
    end else if (sum > 35'sh0_0000_FFFF) begin
        scaled = 16'hFFFF;
    end else begin
        scaled = sum[15:0];
    end
    is_short = meas_ua > short_thr;
    is_break = meas_ua < break_thr;
    fault_now = lfd_en && (is_short || is_break);
    source_val = sim_mode ? sim_value : scaled;
    next_value = source_val;
    if (fault_now) begin
        case (fault_pol)
            `ACVP_POL_CURRENT: begin
                next_value = source_val;
            end
            `ACVP_POL_SUBST: begin
                next_value = sub_value;
            end
            `ACVP_POL_LAST: begin
                next_value = last_valid;
            end
            default: begin
                next_value = source_val;
            end
        endcase
    end
    scale_default = (range_start == `ACVP_RST_START) && (range_end == `ACVP_RST_END);
    next_word = next_value;
    if (status_en && scale_default) begin
        next_word = {next_value[15:4], 2'b00, fault_now, meas_ua <= `ACVP_UA_LIVE_ZERO};
    end
end

// ----------------------------------------
// Standard word update
// ----------------------------------------
always @(posedge aclk) begin
    if (!aresetn) begin
        proc_word <= 16'h0000;
        proc_valid <= 1'b0;
        last_valid <= 16'h0000;
        last_cur <= 16'h0000;
        live_zero <= 1'b0;
        diag_short <= 1'b0;
        diag_break <= 1'b0;
        diag_fault <= 1'b0;
    end else begin
        proc_valid <= meas_valid;
        if (meas_valid) begin
            proc_word <= next_word;
            last_cur <= meas_ua;
            live_zero <= meas_ua <= `ACVP_UA_LIVE_ZERO;
            diag_short <= lfd_en && is_short;
            diag_break <= lfd_en && is_break;
            diag_fault <= fault_now;
            if (!fault_now) begin
                last_valid <= source_val;
            end
        end
    end
end

// ----------------------------------------
// Auxiliary variables and telegram layout
// ----------------------------------------
reg [7:0] aux_div_cnt;
wire aux_tick = meas_valid && (aux_div_cnt == AUX_DIV - 1);

always @(posedge aclk) begin
    if (!aresetn) begin
        aux_div_cnt <= 8'h00;
        aux_valid <= 1'b0;
        cfg_code <= `ACVP_CFG_BASE;
        telegram_len <= `ACVP_STD_BYTES;
        hart_active <= 1'b1;
        hart_scan <= 1'b1;
    end else begin
        // code steps by two per variable
        cfg_code <= `ACVP_CFG_BASE + {4'h0, aux_count, 1'b0};
        // two bytes plus four per variable
        telegram_len <= `ACVP_STD_BYTES + {aux_count, 2'b00};
        hart_active <= feat_indiv_deact ? hart_en : 1'b1;
        hart_scan <= (feat_indiv_deact ? hart_en : 1'b1) && scan_en;
        aux_valid <= aux_tick;
        if (meas_valid) begin
            aux_div_cnt <= aux_tick ? 8'h00 : aux_div_cnt + 8'h01;
        end
    end
end

genvar g;
generate
    for (g = 0; g < 4; g = g + 1) begin : gen_aux
        always @(posedge aclk) begin
            if (!aresetn) begin
                aux_data[g*VAR_W +: VAR_W] <= {VAR_W{1'b0}};
            end else if (aux_tick) begin
                if (g < aux_count && hart_active) begin
                    aux_data[g*VAR_W +: VAR_W] <= hart_var[g*VAR_W +: VAR_W];
                end else begin
                    aux_data[g*VAR_W +: VAR_W] <= {VAR_W{1'b0}};
                end
            end
        end
    end
endgenerate

endmodule

// File: testbench/acvp_channel_assertions.sv
// Checker for the channel's cyclic data, telegram and diagnosis ports.
// Assumes a bind onto acvp_channel with AUX_DIV of at least 2.
`timescale 1ns/100ps
module acvp_channel_assertions #(
    parameter AUX_DIV = 8,
    parameter VAR_W = 32
) (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Sample path
    input wire logic meas_valid,
    input wire logic proc_valid,
    input wire logic aux_valid,
    input wire logic [4*VAR_W-1:0] aux_data,
    // Telegram and diagnosis
    input wire logic [7:0] cfg_code,
    input wire logic [4:0] telegram_len,
    input wire logic diag_short,
    input wire logic diag_break,
    input wire logic diag_fault,
    // HART
    input wire logic feat_indiv_deact,
    input wire logic hart_active,
    input wire logic hart_scan
);
    // ----------------------------------------
    // Properties
    // ----------------------------------------
    default clocking cb @(posedge aclk);
    endclocking
    default disable iff (!aresetn);
    sequence s_sample;
        meas_valid ##1 proc_valid;
    endsequence
    sequence s_aux_once;
        proc_valid ##1 !aux_valid;
    endsequence
    property p_sample;
        meas_valid |-> s_sample;
    endproperty
    property p_cfg;
        cfg_code >= 8'h50 && cfg_code <= 8'h58 && !cfg_code[0];
    endproperty
    property p_len;
        {3'h0, telegram_len} == 8'h02 + ((cfg_code - 8'h50) << 1);
    endproperty
    property p_fault;
        diag_fault == (diag_short || diag_break);
    endproperty
    property p_hart;
        !feat_indiv_deact [*2] |-> hart_active;
    endproperty
    property p_scan;
        hart_scan |-> hart_active || $past(hart_active);
    endproperty
    property p_aux;
        aux_valid |-> s_aux_once;
    endproperty
    property p_aux_zero;
        aux_valid |-> (aux_data >> (({3'h0, telegram_len} - 8'h02) << 3)) == '0;
    endproperty
    a_sample: assert property (p_sample)
        else $error("no data word after a sample");
    a_cfg: assert property (p_cfg)
        else $error("configuration code out of set");
    a_len: assert property (p_len)
        else $error("telegram length does not match code");
    a_fault: assert property (p_fault)
        else $error("fault flag differs from short or break");
    a_hart: assert property (p_hart)
        else $error("hart off without individual deactivation");
    a_scan: assert property (p_scan)
        else $error("scan running on inactive hart channel");
    a_aux: assert property (p_aux)
        else $error("aux refresh not slower than data word");
    a_aux_zero: assert property (p_aux_zero)
        else $error("unused aux slots not zero");
endmodule

bind acvp_channel acvp_channel_assertions #(
    .AUX_DIV(AUX_DIV),
    .VAR_W(VAR_W)
) acvp_channel_assertions_inst (.*);

// File: testbench/acvp_com_unit.sv
// Com unit model: takes the cyclic data and restarts the bus on layout change.
// Assumes the channel's outputs are on the same aclk.
`timescale 1ns/100ps
module acvp_com_unit (
    // Clock and reset
    input wire logic aclk,
    input wire logic aresetn,
    // Cyclic data from the channel
    input wire logic [15:0] proc_word,
    input wire logic proc_valid,
    input wire logic aux_valid,
    input wire logic [7:0] cfg_code,
    // Exchange record
    output logic [15:0] last_word,
    output int n_std,
    output int n_aux,
    output int restarts
);
    logic [7:0] bus_cfg;
    always @(posedge aclk) begin
        if (!aresetn) begin
            bus_cfg <= 8'h50;
            last_word <= 16'h0000;
            n_std <= 0;
            n_aux <= 0;
            restarts <= 0;
        end else if (cfg_code !== bus_cfg) begin
            bus_cfg <= cfg_code;
            restarts <= restarts + 1;
        end else begin
            if (proc_valid) begin
                last_word <= proc_word;
                n_std <= n_std + 1;
            end
            if (aux_valid)
                n_aux <= n_aux + 1;
        end
    end
endmodule

// File: testbench/tb_acvp_channel.sv
// Self-checking bench for one analog channel beside a com unit model.
// Assumes the design, the checker and acvp_com_unit are compiled first.
`timescale 1ns/100ps
module tb_acvp_channel;
    // ----------------------------------------
    // Signals
    // ----------------------------------------
    logic aclk, aresetn, s_axi_awvalid, s_axi_awready, s_axi_wvalid, s_axi_wready;
    logic s_axi_bvalid, s_axi_bready, s_axi_arvalid, s_axi_arready, s_axi_rvalid;
    logic s_axi_rready, meas_valid, proc_valid, aux_valid, feat_indiv_deact;
    logic feat_ext_modes, diag_short, diag_break, diag_fault, hart_active, hart_scan;
    logic [7:0] s_axi_awaddr, s_axi_araddr, cfg_code;
    logic [31:0] s_axi_wdata, s_axi_rdata;
    logic [3:0] s_axi_wstrb;
    logic [1:0] s_axi_bresp, s_axi_rresp;
    logic [15:0] meas_ua, proc_word, last_word;
    logic [127:0] hart_var, aux_data;
    logic [4:0] telegram_len;
    int num_errors, tests_run, n_std, n_aux, restarts;
    acvp_channel #(.AUX_DIV(2)) acvp_channel_inst (.*);
    acvp_com_unit acvp_com_unit_inst (.*);
    // ----------------------------------------
    // Helpers
    // ----------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        tests_run++;
        if (g !== e) begin
            num_errors++;
            $display("[FAIL] %0t got %h exp %h", $time, g, e);
        end
    endtask
    task automatic wrap_up;
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0)
            $display("*** PASS ***");
        else
            $display("*** FAIL ***");
        $finish;
    endtask
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        logic ad;
        logic dd;
        ad = 1'h0;
        dd = 1'h0;
        s_axi_awaddr <= a;
        s_axi_wdata <= d;
        s_axi_awvalid <= 1'h1;
        s_axi_wvalid <= 1'h1;
        while (!(ad && dd)) begin
            @(posedge aclk);
            if (s_axi_awvalid && s_axi_awready) begin
                ad = 1'h1;
                s_axi_awvalid <= 1'h0;
            end
            if (s_axi_wvalid && s_axi_wready) begin
                dd = 1'h1;
                s_axi_wvalid <= 1'h0;
            end
        end
        do @(posedge aclk); while (!s_axi_bvalid);
        chk(s_axi_bresp, e);
    endtask
    task automatic rd(input logic [7:0] a, input logic [31:0] d, input logic [1:0] e);
        s_axi_araddr <= a;
        s_axi_arvalid <= 1'h1;
        do @(posedge aclk); while (!s_axi_arready);
        s_axi_arvalid <= 1'h0;
        do @(posedge aclk); while (!s_axi_rvalid);
        chk(s_axi_rdata, d);
        chk(s_axi_rresp, e);
    endtask
    task automatic ctl(input logic [31:0] v);
        wr(8'h00, v, 2'h0);
        repeat (2) @(posedge aclk);
    endtask
    task automatic smp(input int i);
        meas_ua <= i[15:0];
        meas_valid <= 1'h1;
        @(posedge aclk);
        meas_valid <= 1'h0;
        @(posedge aclk);
        chk(proc_valid, 1'h1);
    endtask
    function automatic logic [15:0] sc(input int i);
        int s;
        s = 10000 + (i - 4000) * 5 / 2;
        if (s > 65535)
            s = 65535;
        return s[15:0];
    endfunction
    function automatic logic [15:0] sw(input logic [15:0] v, input logic f, input int i);
        return {v[15:4], 2'h0, f, i <= 3600};
    endfunction
    // ----------------------------------------
    // Scenarios
    // ----------------------------------------
    task automatic t_reset;
        chk(cfg_code, 8'h50);
        chk(telegram_len, 5'h02);
        chk(hart_active, 1'h1);
        chk(hart_scan, 1'h1);
        rd(8'h00, 32'h0000_0068, 2'h0);
        rd(8'h04, 32'hC350_2710, 2'h0);
        rd(8'h08, 32'h03E8_5208, 2'h0);
        rd(8'h1C, 32'h0000_0000, 2'h2);
        wr(8'h1C, 32'h0000_0001, 2'h2);
        wr(8'h14, 32'h0000_0001, 2'h2);
    endtask
    task automatic t_scale;
        int tbl[5] = '{4000, 12000, 20000, 2000, 30000};
        foreach (tbl[n]) begin
            smp(tbl[n]);
            chk(proc_word, sw(sc(tbl[n]), 1'h0, tbl[n]));
            chk(diag_fault, 1'h0);
        end
        // Com unit takes the word one edge later
        @(posedge aclk);
        chk(last_word, 16'hFFF0);
    endtask
    task automatic t_sim;
        wr(8'h0C, 32'h0000_1234, 2'h0);
        ctl(32'h0000_0069);
        smp(12000);
        chk(proc_word, 16'h1230);
        ctl(32'h0000_0061);
        smp(12000);
        chk(proc_word, 16'h1234);
        ctl(32'h0000_0068);
        wr(8'h04, 32'hC350_2711, 2'h0);
        smp(12004);
        chk(proc_word, 10001 + 8004 * 39999 / 16000);
        wr(8'h04, 32'hC350_2710, 2'h0);
    endtask
    task automatic t_fault;
        int i;
        logic [15:0] v;
        wr(8'h10, 32'h0000_ABCD, 2'h0);
        for (int p = 0; p < 3; p++) begin
            i = (p == 1) ? 500 : 22000;
            v = (p == 0) ? sc(i) : (p == 1) ? 16'hABCD : sc(12000);
            ctl(32'h0000_0078 | (p << 1));
            smp(12000);
            smp(i);
            chk(proc_word, sw(v, 1'h1, i));
            chk(diag_short, i > 21000);
            chk(diag_break, i < 1000);
            chk(diag_fault, 1'h1);
            smp(12000);
            chk(proc_word, 16'h7530);
        end
        rd(8'h14, 32'h7530_5000, 2'h0);
        rd(8'h18, 32'h0000_2EE0, 2'h0);
    endtask
    task automatic t_hart;
        ctl(32'h0000_0048);
        chk(hart_active, 1'h1);
        feat_indiv_deact <= 1'h1;
        ctl(32'h0000_0048);
        chk(hart_active, 1'h0);
        chk(hart_scan, 1'h0);
        ctl(32'h0000_0068);
        chk(hart_scan, 1'h1);
    endtask
    task automatic t_aux;
        int s0;
        int a0;
        ctl(32'h0000_0168);
        chk(cfg_code, 8'h50);
        feat_ext_modes <= 1'h1;
        for (int k = 0; k < 6; k++) begin
            ctl(32'h0000_0068 | (k << 7));
            chk(cfg_code, 8'h50 + 2 * (k > 4 ? 4 : k));
            chk(telegram_len, 2 + 4 * (k > 4 ? 4 : k));
        end
        s0 = n_std;
        a0 = n_aux;
        repeat (4) smp(12000);
        @(posedge aclk);
        chk(n_std - s0, 4);
        chk(n_aux - a0, 2);
        for (int w = 0; w < 4; w++)
            chk(aux_data[32*w +: 32], hart_var[32*w +: 32]);
        chk(restarts, 4);
    endtask
    // ----------------------------------------
    // Clock, watchdog and main sequence
    // ----------------------------------------
    initial begin
        aclk = 1'h0;
        forever #4 aclk = ~aclk;
    end
    initial begin
        repeat (20000) @(posedge aclk);
        num_errors++;
        wrap_up;
    end
    initial begin
        aresetn = 1'h0;
        s_axi_awvalid = 1'h0;
        s_axi_wvalid = 1'h0;
        s_axi_arvalid = 1'h0;
        s_axi_awaddr = 8'h00;
        s_axi_araddr = 8'h00;
        s_axi_wdata = 32'h0000_0000;
        s_axi_wstrb = 4'hF;
        s_axi_bready = 1'h1;
        s_axi_rready = 1'h1;
        meas_ua = 16'h0000;
        meas_valid = 1'h0;
        hart_var = {32'h4444_4444, 32'h3333_3333, 32'h2222_2222, 32'h1111_1111};
        feat_indiv_deact = 1'h0;
        feat_ext_modes = 1'h0;
        num_errors = 0;
        tests_run = 0;
        repeat (10) @(posedge aclk);
        aresetn <= 1'h1;
        @(posedge aclk);
        t_reset;
        t_scale;
        t_sim;
        t_fault;
        t_hart;
        t_aux;
        wrap_up;
    end
endmodule
